// File: hdl/stf_params.svh
// How it works
// - Built-in divider times samples by default
// - External clock select makes pin one clock
// - External sample select makes pin two trigger
// - Trigger ignores rate; filter still uses rate
// - Trigger is active high, idles low
// - One sample set per trigger pulse
// - Buffer holds 512 sixteen-bit entries
// - Mode 00 stores nothing, clears buffer
// - Mode 01 keeps oldest, drops when full
// - Mode 10 keeps newest, discards oldest
// - Watermark when level reaches programmed count
// - Mode 11 captures around activity once
// - Ready, watermark and overrun events raised
// - Entry tag bits: x, y, z, temperature
// - Reads of empty buffer return zero
// - Pin in alternate role never drives
`ifndef STF_PARAMS_SVH
`define STF_PARAMS_SVH

// Register indexes; byte address is four times the index
`define STF_IDX_BUF_CTL 8'h28
`define STF_IDX_SMP_CNT 8'h29
`define STF_IDX_FLT_CTL 8'h2c
`define STF_IDX_PWR_CTL 8'h2d
`define STF_IDX_STATUS 8'h30
`define STF_IDX_LEVEL 8'h31
`define STF_IDX_DATA 8'h32
`define STF_IDX_EVT_MAP 8'h33

// Field positions
`define STF_TEMP_BIT 2
`define STF_AH_BIT 3
`define STF_EXTERNAL_SAMPLE_SELECT_BIT 3
`define STF_EXTERNAL_CLOCK_SELECT_BIT 6
`define STF_MEASURE_ON 2'h2

// Reset values
`define STF_REG_RESET 8'h00

// Buffer geometry
`define STF_DEPTH 10'h200

// Timing
`define STF_CLK_HZ 100000000
`define STF_ODR_TOP_HZ 400
`define STF_EXTERNAL_CLOCK_SELECT_MAX_HZ 51200
`define STF_ODR_TOP_CODE 3'h5

`endif

// File: hdl/stf_pkg.sv
package stf_pkg;

  // Buffer operating modes
  typedef enum logic [1:0] {
    STF_DISABLED = 2'b00,
    STF_OLDEST = 2'b01,
    STF_STREAM = 2'b10,
    STF_TRIGGERED = 2'b11
  } stf_buf_mode_t;

  // State of the top module apart from entry storage
  typedef struct packed {
    logic [7:0] buf_ctl;
    logic [7:0] smp_cnt;
    logic [7:0] flt_ctl;
    logic [7:0] pwr_ctl;
    logic [7:0] evt_map;
    logic [23:0] div_cnt;
    logic [23:0] ext_cnt;
    logic clk_s1;
    logic clk_s2;
    logic clk_s3;
    logic trg_s1;
    logic trg_s2;
    logic trg_s3;
    logic [8:0] wr_ptr;
    logic [8:0] rd_ptr;
    logic [9:0] level;
    logic overrun;
    logic trig_hit;
    logic seq_busy;
    logic [1:0] seq_idx;
    logic [11:0] cap_x;
    logic [11:0] cap_y;
    logic [11:0] cap_z;
    logic [11:0] cap_t;
    logic waitreq;
    logic [31:0] rdata;
    logic pin1_out;
    logic pin1_oe;
    logic pin2_out;
    logic pin2_oe;
    logic conv_start;
    logic [2:0] aa_rate;
  } stf_state_t;

endpackage

// File: hdl/stf_sample_timing.sv
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "stf_params.svh"

module stf_sample_timing #(
  // Cycles between samples at the top rate; shorten for simulation
  parameter logic [23:0] INT_PERIOD_TOP = 24'(`STF_CLK_HZ / `STF_ODR_TOP_HZ)
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic irq_pin_one_in,
  output logic irq_pin_one_out,
  output logic irq_pin_one_oe,
  input wire logic irq_pin_two_in,
  output logic irq_pin_two_out,
  output logic irq_pin_two_oe,
  input wire logic activity_event,
  input wire logic [11:0] sense_x,
  input wire logic [11:0] sense_y,
  input wire logic [11:0] sense_z,
  input wire logic [11:0] sense_temp,
  output logic conv_start,
  output logic [2:0] aa_filter_rate
);

  // External clock edges per sample at the top rate
  localparam logic [23:0] EXT_EDGES_TOP = 24'(`STF_EXTERNAL_CLOCK_SELECT_MAX_HZ / `STF_ODR_TOP_HZ);

  // Stretch a top-rate period to the selected rate; reserved codes run at top rate
  // A shift keeps the divider free of a multiplier, at the cost of power-of-two steps only
  function automatic logic [23:0] scale_period(input logic [23:0] base, input logic [2:0] output_data_rate);
    logic [2:0] shift;
    shift = (output_data_rate > `STF_ODR_TOP_CODE) ? 3'h0 : (`STF_ODR_TOP_CODE - output_data_rate);
    return base << shift;
  endfunction

  // Build a tagged, sign-extended buffer entry
  // Bits 13:12 repeat the sign, so the low fourteen bits read as one signed value
  function automatic logic [15:0] make_entry(input logic [1:0] tag, input logic [11:0] d);
    return {tag, d[11], d[11], d};
  endfunction

  // All registered state except entry storage lives in one struct; n is its next value
  stf_pkg::stf_state_t s; // Current state
  stf_pkg::stf_state_t n; // Next state

  logic [15:0] mem [0:511]; // Entry storage, kept outside the struct
  logic mem_we; // Write strobe into storage
  logic [8:0] mem_wa; // Write address
  logic [15:0] mem_wd; // Write data

  stf_pkg::stf_buf_mode_t mode; // Decoded buffer mode
  logic measuring; // Measurement mode selected
  logic use_trig; // Pin two serves as trigger
  logic use_external_clock_select; // Pin one serves as clock
  logic trg_rise; // Synchronised trigger rising edge
  logic clk_rise; // Synchronised external clock rising edge
  logic tick; // One sample instant
  logic [23:0] int_period; // Internal divider period
  logic [23:0] ext_period; // External edge count per sample
  logic [7:0] idx; // Word index on the bus
  logic req; // New bus request not yet answered
  logic pop; // Host takes one entry
  logic [9:0] lvl; // Working fill level
  logic [8:0] rd; // Working read pointer
  logic [8:0] wr; // Working write pointer
  logic ovr; // Working overrun flag
  logic store; // Store the entry now in sequence
  logic drop_old; // Discard the oldest entry first
  logic last_entry; // Entry in sequence is the final one
  logic [1:0] tag; // Entry type being written
  logic [11:0] tag_data; // Sensor value being written
  logic [8:0] wm_count; // Programmed count with high bit
  logic [9:0] pre_limit; // Pre-event depth in triggered mode
  logic [2:0] status; // Overrun, watermark, ready

  // Static decodes of the current state
  always_comb begin
    mode = stf_pkg::stf_buf_mode_t'(s.buf_ctl[1:0]);
    measuring = (s.pwr_ctl[1:0] == `STF_MEASURE_ON);
    use_trig = s.flt_ctl[`STF_EXTERNAL_SAMPLE_SELECT_BIT];
    use_external_clock_select = s.pwr_ctl[`STF_EXTERNAL_CLOCK_SELECT_BIT];
    // Edge detect looks only at the second and third stages
    trg_rise = s.trg_s2 & ~s.trg_s3;
    clk_rise = s.clk_s2 & ~s.clk_s3;
    int_period = scale_period(INT_PERIOD_TOP, s.flt_ctl[2:0]);
    ext_period = scale_period(EXT_EDGES_TOP, s.flt_ctl[2:0]);
    idx = avs_address[9:2];
    req = (avs_read | avs_write) & s.waitreq;
    wm_count = {s.buf_ctl[`STF_AH_BIT], s.smp_cnt};
    // A zero count means the whole depth before the event
    pre_limit = (wm_count == 9'h000) ? `STF_DEPTH : {1'b0, wm_count};
    // Ready and watermark are levels; only overrun is sticky
    status[0] = (s.level != 10'h000);
    status[1] = (wm_count != 9'h000) && (s.level >= {1'b0, wm_count});
    status[2] = s.overrun;
  end

  // Next-state logic for the whole block
  always_comb begin
    n = s;
    mem_we = 1'b0;
    mem_wa = s.wr_ptr;
    mem_wd = 16'h0000;
    tick = 1'b0;
    store = 1'b0;
    drop_old = 1'b0;
    last_entry = 1'b0;
    tag = s.seq_idx;
    tag_data = 12'h000;

    // Two-stage synchronisers plus one stage for edge detection
    n.trg_s1 = irq_pin_two_in;
    n.trg_s2 = s.trg_s1;
    n.trg_s3 = s.trg_s2;
    n.clk_s1 = irq_pin_one_in;
    n.clk_s2 = s.clk_s1;
    n.clk_s3 = s.clk_s2;

    // Sample timing: trigger, external clock, or built-in divider
    // The trigger wins when both alternate pin roles are selected
    n.conv_start = 1'b0;
    if (!measuring) begin
      n.div_cnt = 24'h000000;
      n.ext_cnt = 24'h000000;
    end else if (use_trig) begin
      // Programmed rate plays no part in timing here
      n.div_cnt = 24'h000000;
      n.ext_cnt = 24'h000000;
      tick = trg_rise;
    end else if (use_external_clock_select) begin
      n.div_cnt = 24'h000000;
      // Count synchronised edges of pin one; the divider sleeps meanwhile
      if (clk_rise) begin
        if (s.ext_cnt + 24'h000001 >= ext_period) begin
          n.ext_cnt = 24'h000000;
          tick = 1'b1;
        end else begin
          n.ext_cnt = s.ext_cnt + 24'h000001;
        end
      end
    end else begin
      n.ext_cnt = 24'h000000;
      if (s.div_cnt + 24'h000001 >= int_period) begin
        n.div_cnt = 24'h000000;
        tick = 1'b1;
      end else begin
        n.div_cnt = s.div_cnt + 24'h000001;
      end
    end

    // Filter always follows the programmed rate bits
    n.aa_rate = s.flt_ctl[2:0];

    // Host read of the data register pops one entry
    // A read of an empty buffer neither pops nor moves the read pointer
    pop = req & avs_read & (idx == `STF_IDX_DATA) & (s.level != 10'h000);
    lvl = s.level - {9'h000, pop};
    rd = s.rd_ptr + {8'h00, pop};
    wr = s.wr_ptr;
    // Overrun clears on a pop; a new overrun below still wins
    ovr = s.overrun & ~pop;

    // Write one entry per cycle of a sample sequence
    if (s.seq_busy) begin
      unique case (s.seq_idx)
        2'h0: tag_data = s.cap_x;
        2'h1: tag_data = s.cap_y;
        2'h2: tag_data = s.cap_z;
        2'h3: tag_data = s.cap_t;
      endcase
      last_entry = (s.seq_idx == 2'h3) ||
                   ((s.seq_idx == 2'h2) && !s.buf_ctl[`STF_TEMP_BIT]);
      // Mode is read per entry, so a change acts from the next write on
      unique case (mode)
        stf_pkg::STF_DISABLED: begin
          store = 1'b0;
        end
        stf_pkg::STF_OLDEST: begin
          if (lvl == `STF_DEPTH) begin
            ovr = 1'b1;
          end else begin
            store = 1'b1;
          end
        end
        stf_pkg::STF_STREAM: begin
          if (lvl == `STF_DEPTH) begin
            drop_old = 1'b1;
            ovr = 1'b1;
          end
          store = 1'b1;
        end
        stf_pkg::STF_TRIGGERED: begin
          if (s.trig_hit) begin
            // After the event, fill once and then hold
            store = (lvl != `STF_DEPTH);
          end else begin
            // Before the event, keep only the pre-event depth
            drop_old = (lvl >= pre_limit);
            store = 1'b1;
          end
        end
      endcase
      n.seq_idx = s.seq_idx + 2'h1;
      if (last_entry) begin
        n.seq_busy = 1'b0;
      end
    end

    // Apply discard then store
    // Discarding first keeps a full buffer from ever counting past its depth
    if (drop_old) begin
      rd = rd + 9'h001;
      lvl = lvl - 10'h001;
    end
    if (store) begin
      mem_we = 1'b1;
      mem_wa = wr;
      mem_wd = make_entry(tag, tag_data);
      wr = wr + 9'h001;
      lvl = lvl + 10'h001;
    end
    n.rd_ptr = rd;
    n.wr_ptr = wr;
    n.level = lvl;
    n.overrun = ovr;

    // Start a new sample set; a tick during a sequence cannot occur at legal rates
    if (tick && !s.seq_busy) begin
      n.conv_start = 1'b1;
      n.seq_busy = 1'b1;
      n.seq_idx = 2'h0;
      n.cap_x = sense_x;
      n.cap_y = sense_y;
      n.cap_z = sense_z;
      n.cap_t = sense_temp;
    end

    // Disabled buffer holds nothing and forgets everything
    if (mode == stf_pkg::STF_DISABLED) begin
      n.rd_ptr = 9'h000;
      n.wr_ptr = 9'h000;
      n.level = 10'h000;
      n.overrun = 1'b0;
      n.trig_hit = 1'b0;
    end

    // Bus: answer one cycle after a request, then rearm
    // The rearm cycle keeps a request still held by the master from being taken twice
    if (!s.waitreq) begin
      n.waitreq = 1'b1;
    end else if (req) begin
      n.waitreq = 1'b0;
      n.rdata = 32'h00000000;
      if (avs_read) begin
        unique case (idx)
          `STF_IDX_BUF_CTL: n.rdata = {24'h000000, s.buf_ctl};
          `STF_IDX_SMP_CNT: n.rdata = {24'h000000, s.smp_cnt};
          `STF_IDX_FLT_CTL: n.rdata = {24'h000000, s.flt_ctl};
          `STF_IDX_PWR_CTL: n.rdata = {24'h000000, s.pwr_ctl};
          `STF_IDX_STATUS: n.rdata = {29'h00000000, status};
          `STF_IDX_LEVEL: n.rdata = {22'h000000, s.level};
          `STF_IDX_EVT_MAP: n.rdata = {24'h000000, s.evt_map};
          // Empty buffer reads as zero
          `STF_IDX_DATA: n.rdata = pop ? {16'h0000, mem[s.rd_ptr]} : 32'h00000000;
          default: n.rdata = 32'h00000000;
        endcase
      end else if (avs_byteenable[0]) begin
        // Writes with byte lane zero off never reach here; unmapped indexes are ignored
        unique case (idx)
          `STF_IDX_BUF_CTL: begin
            n.buf_ctl = avs_writedata[7:0];
            // A new mode rearms the one-shot capture
            if (avs_writedata[1:0] != s.buf_ctl[1:0]) begin
              n.trig_hit = 1'b0;
            end
          end
          `STF_IDX_SMP_CNT: n.smp_cnt = avs_writedata[7:0];
          `STF_IDX_FLT_CTL: n.flt_ctl = avs_writedata[7:0];
          `STF_IDX_PWR_CTL: n.pwr_ctl = avs_writedata[7:0];
          `STF_IDX_EVT_MAP: n.evt_map = avs_writedata[7:0];
          default: n.rdata = 32'h00000000;
        endcase
      end
    end

    // Activity arms the one-shot capture; it comes after the bus so that an event
    // in the same cycle as a rewrite away from triggered mode still arms it, the set winning over the clear
    // Activity is ignored outside triggered mode
    if ((mode == stf_pkg::STF_TRIGGERED) && activity_event) begin
      n.trig_hit = 1'b1;
    end

    // Pins drive events only while not serving an input role
    // Both enables follow the map, so an unmapped pin stays released
    n.pin1_oe = ~use_external_clock_select & (|s.evt_map[2:0]);
    n.pin1_out = ~use_external_clock_select & (|(status & s.evt_map[2:0]));
    n.pin2_oe = ~use_trig & (|s.evt_map[6:4]);
    n.pin2_out = ~use_trig & (|(status & s.evt_map[6:4]));
  end

  // State register; reset gives a quiet, disabled block
  // Waitrequest leaves reset high, so the first request is taken on the first edge after it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s <= '0;
      s.buf_ctl <= `STF_REG_RESET;
      s.smp_cnt <= `STF_REG_RESET;
      s.flt_ctl <= `STF_REG_RESET;
      s.pwr_ctl <= `STF_REG_RESET;
      s.evt_map <= `STF_REG_RESET;
      s.waitreq <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Entry storage has no reset; level and pointers define validity
  always_ff @(posedge clock) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.waitreq;
  assign irq_pin_one_out = s.pin1_out;
  assign irq_pin_one_oe = s.pin1_oe;
  assign irq_pin_two_out = s.pin2_out;
  assign irq_pin_two_oe = s.pin2_oe;
  assign conv_start = s.conv_start;
  assign aa_filter_rate = s.aa_rate;

endmodule // stf_sample_timing

`default_nettype wire

// File: bench/stf_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module stf_assertions (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq_pin_one_oe,
  input wire logic irq_pin_two_in,
  input wire logic irq_pin_two_oe,
  input wire logic conv_start,
  input wire logic [2:0] aa_filter_rate
);
  logic [7:0] idx; // Word index of the request
  logic ans_w; // Write accepted at this edge
  logic trg_m; // Mirror of trigger select, one cycle late
  logic meas_m; // Mirror of measure mode, one cycle late
  assign idx = avs_address[9:2];
  assign ans_w = !avs_waitrequest && avs_write && avs_byteenable[0];
  // Mirrors lag the device by one edge, so the properties leave slack
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      trg_m <= 1'b0;
      meas_m <= 1'b0;
    end else if (ans_w && idx == 8'h2c) begin
      trg_m <= avs_writedata[3];
    end else if (ans_w && idx == 8'h2d) begin
      meas_m <= avs_writedata[1:0] == 2'h2;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  AST_CONV_GAP: assert property (conv_start |=> !conv_start [*3])
    else $error("sample sets overlap");
  AST_PIN1_QUIET: assert property (ans_w && idx == 8'h2d && avs_writedata[6] |=> !irq_pin_one_oe)
    else $error("pin one driven as clock input");
  AST_PIN2_QUIET: assert property (ans_w && idx == 8'h2c && avs_writedata[3] |=> !irq_pin_two_oe)
    else $error("pin two driven as trigger input");
  AST_AA_RATE: assert property (ans_w && idx == 8'h2c |=> aa_filter_rate == $past(avs_writedata[2:0]))
    else $error("filter rate not taken from rate bits");
  AST_TRIG_CONV: assert property (trg_m && meas_m && $rose(irq_pin_two_in) |-> ##[1:5] conv_start)
    else $error("trigger edge started no sample set");
  AST_IDLE: assert property (!meas_m && !$past(meas_m) |-> !conv_start)
    else $error("sample set outside measure mode");
  AST_SIGN: assert property (!avs_waitrequest && avs_read && idx == 8'h32 |-> avs_readdata[13:12] == {2{avs_readdata[11]}})
    else $error("entry sign extension wrong");
endmodule // stf_assertions
bind stf_sample_timing stf_assertions u_chk (
  .clock(clock), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .irq_pin_one_oe(irq_pin_one_oe), .irq_pin_two_in(irq_pin_two_in),
  .irq_pin_two_oe(irq_pin_two_oe), .conv_start(conv_start), .aa_filter_rate(aa_filter_rate)
);
`default_nettype wire

// File: bench/stf_far_side.sv
`timescale 1ns/100ps
`default_nettype none
module stf_far_side #(
  parameter int HI_CYC = 2500, // 25 us at 100 MHz
  parameter int LO_CYC = 2500 // 25 us at 100 MHz
) (
  input wire logic clock,
  output logic trig,
  output logic external_clock_select
);
  // Trigger idles low; clock pin stands still, far below its top rate
  initial begin
    trig = 1'b0;
    external_clock_select = 1'b0;
  end
  // One trigger pulse; pulse spacing is shortened so the run stays short
  task pulse;
    trig <= 1'b1;
    repeat (HI_CYC) @(posedge clock);
    trig <= 1'b0;
    repeat (LO_CYC) @(posedge clock);
  endtask
endmodule // stf_far_side
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clock = 1'b0; // 100 MHz
  logic sys_rst = 1'b1; // Held for 5 cycles
  logic [9:0] adr = 10'h000; // Bus byte address
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h00000000;
  logic [31:0] rdat;
  logic wreq;
  logic o1, e1, o2, e2, cs;
  logic [2:0] aa;
  logic act = 1'b0; // Activity pulse into the buffer
  logic [11:0] sv [4] = '{12'h8a1, 12'h123, 12'hfff, 12'h456}; // x y z temp
  wire trig;
  wire eclk;
  wire pin1;
  wire pin2;
  logic [31:0] q; // Last read data
  int error_cnt = 0;
  int n_checks = 0;
  int conv_cnt = 0; // Sample sets seen
  int c0;
  always #5 clock = ~clock;
  // Wire level: device when enabled, else the far side
  assign pin1 = e1 ? o1 : eclk;
  assign pin2 = e2 ? o2 : trig;
  always @(posedge clock) if (cs === 1'b1) conv_cnt <= conv_cnt + 1;
  stf_far_side u_far (.clock(clock), .trig(trig), .external_clock_select(eclk));
  stf_sample_timing #(.INT_PERIOD_TOP(24'h000014)) u_dut (
    .clock(clock), .sys_rst(sys_rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(4'h1), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .irq_pin_one_in(pin1), .irq_pin_one_out(o1), .irq_pin_one_oe(e1),
    .irq_pin_two_in(pin2), .irq_pin_two_out(o2), .irq_pin_two_oe(e2),
    .activity_event(act), .sense_x(sv[0]), .sense_y(sv[1]), .sense_z(sv[2]),
    .sense_temp(sv[3]), .conv_start(cs), .aa_filter_rate(aa));
  task wrap_up;
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One bus cycle; held until waitrequest is sampled low
  task xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
    int k;
    adr <= {i, 2'b00};
    wd <= {24'h000000, d};
    wr <= w;
    rd <= !w;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (wreq !== 1'b0 && k < 40);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (k >= 40) begin
      error_cnt++;
      wrap_up();
    end
    @(posedge clock);
  endtask
  // Poll the fill level until it reaches n
  task wait_lvl(input logic [9:0] n);
    int k;
    k = 0;
    do begin
      xfer(1'b0, 8'h31, 8'h00);
      k++;
    end while (q[9:0] < n && k < 4000);
    if (k >= 4000) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  task t_regs;
    xfer(1'b0, 8'h28, 8'h00);
    chk(q, 32'h0);
    xfer(1'b1, 8'h29, 8'ha5);
    xfer(1'b0, 8'h29, 8'h00);
    chk(q, 32'ha5);
    xfer(1'b0, 8'h3f, 8'h00);
    chk(q, 32'h0);
  endtask
  // Internal rate, temperature stored, watermark at 4
  task t_internal;
    xfer(1'b1, 8'h29, 8'h04);
    xfer(1'b1, 8'h2c, 8'h05);
    xfer(1'b1, 8'h28, 8'h05);
    xfer(1'b1, 8'h33, 8'h03);
    xfer(1'b1, 8'h2d, 8'h02);
    wait_lvl(10'h004);
    xfer(1'b1, 8'h2d, 8'h00);
    xfer(1'b0, 8'h30, 8'h00);
    chk({30'h0, q[1:0]}, 32'h3);
    chk({30'h0, e1, o1}, 32'h3);
    for (int j = 0; j < 4; j++) begin
      xfer(1'b0, 8'h32, 8'h00);
      chk(q, {16'h0, 2'(j), {2{sv[j][11]}}, sv[j]});
    end
    xfer(1'b1, 8'h28, 8'h00);
    xfer(1'b0, 8'h31, 8'h00);
    chk(q, 32'h0);
    xfer(1'b0, 8'h32, 8'h00);
    chk(q, 32'h0);
  endtask
  // 171st set overflows: 510 entries plus two
  task t_full;
    xfer(1'b1, 8'h28, 8'h01);
    xfer(1'b1, 8'h2d, 8'h02);
    wait_lvl(10'h200);
    xfer(1'b0, 8'h30, 8'h00);
    chk({29'h0, q[2:0]}, 32'h7);
    xfer(1'b1, 8'h28, 8'h02);
    repeat (100) @(posedge clock);
    xfer(1'b0, 8'h31, 8'h00);
    chk(q, 32'h200);
    xfer(1'b1, 8'h2d, 8'h00);
    xfer(1'b1, 8'h28, 8'h00);
  endtask
  // Three pulses, internal rate would give far more sets
  task t_trigger;
    xfer(1'b1, 8'h33, 8'h70);
    xfer(1'b1, 8'h28, 8'h01);
    xfer(1'b1, 8'h2c, 8'h4b);
    xfer(1'b1, 8'h2d, 8'h02);
    c0 = conv_cnt;
    repeat (3) u_far.pulse();
    xfer(1'b1, 8'h2d, 8'h00);
    chk(32'(conv_cnt - c0), 32'h3);
    xfer(1'b0, 8'h31, 8'h00);
    chk(q, 32'h9);
    chk({31'h0, e2}, 32'h0);
    chk({29'h0, aa}, 32'h3);
    xfer(1'b1, 8'h2c, 8'h05);
    xfer(1'b1, 8'h28, 8'h00);
  endtask
  // Triggered mode: three held before activity, then one fill with no overrun
  task t_capture;
    xfer(1'b1, 8'h29, 8'h03);
    xfer(1'b1, 8'h28, 8'h03);
    xfer(1'b1, 8'h2d, 8'h02);
    repeat (300) @(posedge clock);
    xfer(1'b0, 8'h31, 8'h00);
    chk(q, 32'h3);
    chk({30'h0, e2, o2}, 32'h3);
    act <= 1'b1;
    @(posedge clock);
    act <= 1'b0;
    wait_lvl(10'h200);
    repeat (100) @(posedge clock);
    xfer(1'b0, 8'h30, 8'h00);
    chk({29'h0, q[2:0]}, 32'h3);
    xfer(1'b1, 8'h2d, 8'h00);
    xfer(1'b1, 8'h28, 8'h00);
  endtask
  // Clock pin stands still, so no set may appear
  task t_extclk;
    xfer(1'b1, 8'h28, 8'h01);
    xfer(1'b1, 8'h33, 8'h01);
    xfer(1'b1, 8'h2d, 8'h42);
    repeat (200) @(posedge clock);
    xfer(1'b0, 8'h31, 8'h00);
    chk(q, 32'h0);
    chk({31'h0, e1}, 32'h0);
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    t_regs();
    t_internal();
    t_full();
    t_trigger();
    t_capture();
    t_extclk();
    wrap_up();
  end
endmodule // tb
`default_nettype wire
